// file: shared/pidss_pkg.sv
// constants and types for the package idle state sequencer
// Function
// - core halt keeps package active
// - enhanced halt uses lowest operating point
// - C2 only when all cores C3+ or a system sleep is requested
// - C3 flushes core caches, stops clocks
// - C6 saves state before supply off
// - C7 flushes ways, then cache supply off
// - C8 same shared cache flush as C7, but a wake does not cut the flush short
// - C9 drops uncore rails, keeps io
// - C10 regulators deepest, 24 MHz off
// - powered up holds clock enable high
// - precharge powerdown closes banks first
// - active powerdown with open bank
// - self refresh keeps memory contents
// - suspend to memory cold only
// - soft off needs full reboot
// - core state is shallowest thread request
// - idle changes pass through active
package pidss_pkg;
  // encoded idle depth (c-state codes)
  localparam logic [3:0] CS_C0 = 4'h0;
  localparam logic [3:0] CS_C1 = 4'h1;
  localparam logic [3:0] CS_C1E = 4'h2;
  localparam logic [3:0] CS_C2 = 4'h3;
  localparam logic [3:0] CS_C3 = 4'h4;
  localparam logic [3:0] CS_C6 = 4'h5;
  localparam logic [3:0] CS_C7 = 4'h6;
  localparam logic [3:0] CS_C8 = 4'h7;
  localparam logic [3:0] CS_C9 = 4'h8;
  localparam logic [3:0] CS_C10 = 4'h9;
  // sleep requests
  localparam logic [1:0] SLP_S0 = 2'h0;
  localparam logic [1:0] SLP_S3 = 2'h1;
  localparam logic [1:0] SLP_S4 = 2'h2;
  localparam logic [1:0] SLP_S5 = 2'h3;
  // memory clock-enable modes
  localparam logic [1:0] MEM_UP = 2'h0;
  localparam logic [1:0] MEM_PPD = 2'h1;
  localparam logic [1:0] MEM_APD = 2'h2;
  localparam logic [1:0] MEM_SR = 2'h3;
  localparam int STEP_TIMEOUT = 256;
  typedef enum logic [10:0] {
    PIDSS_ACTIVE = 11'h001,
    PIDSS_C2 = 11'h002,
    PIDSS_FLUSH_CORE = 11'h004,
    PIDSS_CLK_OFF = 11'h008,
    PIDSS_SAVE = 11'h010,
    PIDSS_CORE_OFF = 11'h020,
    PIDSS_LLC_FLUSH = 11'h040,
    PIDSS_UNCORE = 11'h080,
    PIDSS_DEEP = 11'h100,
    PIDSS_IDLE = 11'h200,
    PIDSS_WAKE = 11'h400
  } pidss_state_t;
endpackage : pidss_pkg

// file: shared/pidss_cores_if.sv
// per-core request and handshake bundle
interface pidss_cores_if #(parameter int NCORE = 4, parameter int NTHR = 2);
  logic [3:0] thr_req [NCORE][NTHR];
  logic [3:0] core_state [NCORE];
  logic [NCORE-1:0] core_c0;
  modport resolver (input thr_req, output core_state, output core_c0);
  modport user (input core_state, input core_c0);
endinterface : pidss_cores_if

// file: src/pidss_resolve.sv
// resolves each core state from its thread requests
module pidss_resolve #(
  parameter int NCORE = 4,
  parameter int NTHR = 2
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_nrst, // sync reset, active low
  pidss_cores_if.resolver cif // requests in, core states out
);
  logic [3:0] res [NCORE];
  logic [3:0] prev_reg [NCORE];
  always_comb
  begin
    for (int c = 0; c < NCORE; c++)
    begin
      res[c] = 4'hf;
      for (int t = 0; t < NTHR; t++)
        if (cif.thr_req[c][t] < res[c])
          res[c] = cif.thr_req[c][t];
    end
  end
  always_ff @(posedge i_clk_sys)
  begin
    for (int c = 0; c < NCORE; c++)
    begin
      if (!i_nrst)
        prev_reg[c] <= pidss_pkg::CS_C0;
      // idle to idle goes via active
      else if (prev_reg[c] != pidss_pkg::CS_C0 && res[c] != prev_reg[c])
        prev_reg[c] <= pidss_pkg::CS_C0;
      else
        prev_reg[c] <= res[c];
    end
  end
  always_comb
  begin
    for (int c = 0; c < NCORE; c++)
    begin
      cif.core_state[c] = prev_reg[c];
      cif.core_c0[c] = (prev_reg[c] == pidss_pkg::CS_C0);
    end
  end
endmodule : pidss_resolve

// file: src/pidss_top.sv
// package idle state sequencer top
module pidss_top #(
  parameter int NCORE = 4,
  parameter int NTHR = 2
) (
  input wire logic i_clk_sys, // 200 MHz clock
  input wire logic i_nrst, // sync reset, active low
  input wire logic [4*NCORE*NTHR-1:0] i_thr_req, // thread c-state codes
  input wire logic [3:0] i_plat_limit, // deepest allowed package code
  input wire logic i_llc_flush_en, // optional flush in C3
  input wire logic i_wake, // wake event
  input wire logic [1:0] i_sleep_req, // system sleep request
  input wire logic [NCORE-1:0] i_flush_done, // per-core cache written back
  input wire logic [NCORE-1:0] i_save_done, // per-core state saved
  input wire logic [NCORE-1:0] i_restore_done, // per-core state restored
  input wire logic i_llc_flush_done, // whole shared cache flushed
  input wire logic i_rails_good, // supplies settled
  input wire logic i_mem_idle, // memory traffic idle
  input wire logic i_bank_open, // at least one bank open
  input wire logic i_banks_closed_ack, // precharge all finished
  output logic [3:0] o_pkg_state, // current package c-state code
  output logic o_min_op_point, // lowest frequency/voltage point
  output logic [NCORE-1:0] o_core_flush, // core cache write-back request
  output logic [NCORE-1:0] o_core_clk_en, // core clock enable
  output logic [NCORE-1:0] o_core_save, // core state save request
  output logic [NCORE-1:0] o_core_restore, // core state restore request
  output logic [NCORE-1:0] o_core_pwr_en, // core supply enable
  output logic o_llc_flush, // shared cache flush request
  output logic o_llc_pwr_en, // shared cache supply enable
  output logic o_uncore_pwr_en, // compute, graphics, agent rails
  output logic o_io_pwr_en, // io supply enable
  output logic o_deepest_regulator_state, // regulators in deepest state
  output logic o_ref_clk_en, // base reference clock enable
  output logic o_clk24_en, // 24 MHz clock enable
  output logic o_mem_close_banks, // precharge all request
  output logic o_mem_cke, // memory clock enable
  output logic o_mem_self_refresh, // self refresh engaged
  output logic o_mem_ctx_kept, // context held in memory
  output logic o_reboot_req // full reboot needed on resume
);
  pidss_cores_if #(.NCORE(NCORE), .NTHR(NTHR)) cif ();
  pidss_resolve #(.NCORE(NCORE), .NTHR(NTHR)) u_res (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .cif(cif)
  );
  always_comb
  begin
    for (int c = 0; c < NCORE; c++)
      for (int t = 0; t < NTHR; t++)
        cif.thr_req[c][t] = i_thr_req[4*(c*NTHR+t) +: 4];
  end

  // shallowest core state, bounded by platform limit
  function automatic logic [3:0] min_core(input logic [3:0] s [NCORE]);
    logic [3:0] m;
    m = 4'hf;
    for (int c = 0; c < NCORE; c++)
      if (s[c] < m)
        m = s[c];
    return m;
  endfunction : min_core

  logic [3:0] all_min;
  logic [3:0] target;
  always_comb
  begin
    all_min = min_core(cif.core_state);
    target = (all_min < i_plat_limit) ? all_min : i_plat_limit;
  end

  pidss_pkg::pidss_state_t st_reg;
  logic [3:0] pkg_reg;
  logic [3:0] goal_reg;
  logic deep_sleep;
  assign deep_sleep = (i_sleep_req != pidss_pkg::SLP_S0);

  // entry walks deeper states; wake in PIDSS_C2 returns straight to active, from deeper states through PIDSS_WAKE to active
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      st_reg <= pidss_pkg::PIDSS_ACTIVE;
      goal_reg <= pidss_pkg::CS_C0;
    end
    else
    begin
      unique case (st_reg)
        pidss_pkg::PIDSS_ACTIVE:
          // C2 only when all cores C3 or deeper, or on a system sleep request
          if (!i_wake && (target >= pidss_pkg::CS_C3 || deep_sleep))
          begin
            goal_reg <= deep_sleep ? pidss_pkg::CS_C10 : target;
            st_reg <= pidss_pkg::PIDSS_C2;
          end
        pidss_pkg::PIDSS_C2:
          if (i_wake || target < pidss_pkg::CS_C3 && !deep_sleep)
            st_reg <= pidss_pkg::PIDSS_ACTIVE;
          else
            st_reg <= pidss_pkg::PIDSS_FLUSH_CORE;
        pidss_pkg::PIDSS_FLUSH_CORE:
          if (&i_flush_done)
            st_reg <= pidss_pkg::PIDSS_CLK_OFF;
        pidss_pkg::PIDSS_CLK_OFF:
          st_reg <= (goal_reg >= pidss_pkg::CS_C6) ? pidss_pkg::PIDSS_SAVE
                                                    : pidss_pkg::PIDSS_IDLE;
        pidss_pkg::PIDSS_SAVE:
          if (&i_save_done)
            st_reg <= pidss_pkg::PIDSS_CORE_OFF;
        pidss_pkg::PIDSS_CORE_OFF:
          st_reg <= (goal_reg >= pidss_pkg::CS_C7) ? pidss_pkg::PIDSS_LLC_FLUSH
                                                    : pidss_pkg::PIDSS_IDLE;
        pidss_pkg::PIDSS_LLC_FLUSH:
          // cache supply off only after full flush
          if (i_llc_flush_done)
            st_reg <= (goal_reg >= pidss_pkg::CS_C9) ? pidss_pkg::PIDSS_UNCORE
                                                      : pidss_pkg::PIDSS_IDLE;
          else if (i_wake && goal_reg == pidss_pkg::CS_C7)
            st_reg <= pidss_pkg::PIDSS_WAKE;
        pidss_pkg::PIDSS_UNCORE:
          st_reg <= (goal_reg >= pidss_pkg::CS_C10) ? pidss_pkg::PIDSS_DEEP
                                                     : pidss_pkg::PIDSS_IDLE;
        pidss_pkg::PIDSS_DEEP:
          st_reg <= pidss_pkg::PIDSS_IDLE;
        pidss_pkg::PIDSS_IDLE:
          if (i_wake)
            st_reg <= pidss_pkg::PIDSS_WAKE;
        pidss_pkg::PIDSS_WAKE:
          // supplies and clocks first, then restore
          if (i_rails_good && (&i_restore_done || goal_reg < pidss_pkg::CS_C6))
            st_reg <= pidss_pkg::PIDSS_ACTIVE;
        default:
          st_reg <= pidss_pkg::PIDSS_ACTIVE;
      endcase
    end
  end

  // package code reported
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      pkg_reg <= pidss_pkg::CS_C0;
    else if (st_reg == pidss_pkg::PIDSS_IDLE)
      pkg_reg <= goal_reg;
    else if (st_reg == pidss_pkg::PIDSS_ACTIVE)
      pkg_reg <= pidss_pkg::CS_C0;
    else if (st_reg == pidss_pkg::PIDSS_C2)
      pkg_reg <= pidss_pkg::CS_C2;
  end
  assign o_pkg_state = pkg_reg;

  // cumulative entry actions, released on wake
  logic in_wake;
  logic down;
  assign in_wake = (st_reg == pidss_pkg::PIDSS_WAKE);
  assign down = !(st_reg inside {pidss_pkg::PIDSS_ACTIVE, pidss_pkg::PIDSS_C2,
                                 pidss_pkg::PIDSS_FLUSH_CORE});
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_min_op_point <= 1'b0;
      o_core_flush <= '0;
      o_core_clk_en <= '1;
      o_core_save <= '0;
      o_core_restore <= '0;
      o_core_pwr_en <= '1;
      o_llc_flush <= 1'b0;
      o_llc_pwr_en <= 1'b1;
      o_uncore_pwr_en <= 1'b1;
      o_io_pwr_en <= 1'b1;
      o_deepest_regulator_state <= 1'b0;
      o_ref_clk_en <= 1'b1;
      o_clk24_en <= 1'b1;
    end
    else
    begin
      o_min_op_point <= (st_reg == pidss_pkg::PIDSS_ACTIVE) &&
                        (all_min == pidss_pkg::CS_C1E);
      o_core_flush <= {NCORE{st_reg == pidss_pkg::PIDSS_FLUSH_CORE}};
      o_core_clk_en <= {NCORE{!down || in_wake && i_rails_good}};
      o_core_save <= {NCORE{st_reg == pidss_pkg::PIDSS_SAVE}};
      o_core_restore <= {NCORE{in_wake && i_rails_good &&
                               goal_reg >= pidss_pkg::CS_C6}};
      o_core_pwr_en <= {NCORE{!(down && goal_reg >= pidss_pkg::CS_C6 &&
                          st_reg != pidss_pkg::PIDSS_CLK_OFF &&
                          st_reg != pidss_pkg::PIDSS_SAVE) || in_wake}};
      o_llc_flush <= (st_reg == pidss_pkg::PIDSS_LLC_FLUSH) ||
                     (st_reg == pidss_pkg::PIDSS_FLUSH_CORE &&
                      i_llc_flush_en);
      o_llc_pwr_en <= !(down && goal_reg >= pidss_pkg::CS_C7 &&
                        st_reg inside {pidss_pkg::PIDSS_UNCORE,
                          pidss_pkg::PIDSS_DEEP, pidss_pkg::PIDSS_IDLE}) ||
                      in_wake;
      // rails to zero, io stays on except in idle with an S5 request
      o_uncore_pwr_en <= !(down && goal_reg >= pidss_pkg::CS_C9 &&
                           st_reg inside {pidss_pkg::PIDSS_DEEP,
                                          pidss_pkg::PIDSS_IDLE}) || in_wake;
      o_io_pwr_en <= !(st_reg == pidss_pkg::PIDSS_IDLE &&
                       i_sleep_req == pidss_pkg::SLP_S5);
      o_deepest_regulator_state <= st_reg == pidss_pkg::PIDSS_IDLE &&
                                   goal_reg >= pidss_pkg::CS_C10;
      o_clk24_en <= !(st_reg == pidss_pkg::PIDSS_IDLE &&
                      goal_reg >= pidss_pkg::CS_C10);
      o_ref_clk_en <= !(st_reg == pidss_pkg::PIDSS_IDLE &&
                        goal_reg >= pidss_pkg::CS_C6);
    end
  end

  // memory clock-enable mode
  logic [1:0] mem_mode;
  always_comb
  begin
    // self refresh only in package idle at C3 or deeper; powerdown whenever memory idle
    if (st_reg == pidss_pkg::PIDSS_IDLE && goal_reg >= pidss_pkg::CS_C3)
      mem_mode = pidss_pkg::MEM_SR;
    else if (i_mem_idle && i_bank_open)
      mem_mode = pidss_pkg::MEM_APD;
    else if (i_mem_idle)
      mem_mode = pidss_pkg::MEM_PPD;
    else
      mem_mode = pidss_pkg::MEM_UP;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_mem_cke <= 1'b1;
      o_mem_self_refresh <= 1'b0;
      o_mem_close_banks <= 1'b0;
    end
    else
    begin
      unique case (mem_mode)
        pidss_pkg::MEM_UP:
        begin
          o_mem_cke <= 1'b1;
          o_mem_self_refresh <= 1'b0;
          o_mem_close_banks <= 1'b0;
        end
        pidss_pkg::MEM_PPD:
        begin
          o_mem_close_banks <= !i_banks_closed_ack;
          o_mem_cke <= !i_banks_closed_ack;
          o_mem_self_refresh <= 1'b0;
        end
        // open bank, cke low, no refresh
        pidss_pkg::MEM_APD:
        begin
          o_mem_cke <= 1'b0;
          o_mem_self_refresh <= 1'b0;
          o_mem_close_banks <= 1'b0;
        end
        pidss_pkg::MEM_SR:
        begin
          o_mem_cke <= 1'b0;
          o_mem_self_refresh <= 1'b1;
          o_mem_close_banks <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_mem_ctx_kept <= 1'b0;
      o_reboot_req <= 1'b0;
    end
    else
    begin
      o_mem_ctx_kept <= (i_sleep_req == pidss_pkg::SLP_S3) &&
                        (st_reg == pidss_pkg::PIDSS_IDLE);
      o_reboot_req <= (i_sleep_req == pidss_pkg::SLP_S5) &&
                      (st_reg == pidss_pkg::PIDSS_IDLE);
    end
  end
endmodule : pidss_top

// file: testbench/pidss_chk.sv
// port assertions for the package idle state sequencer
module pidss_chk #(
  parameter int NCORE = 4,
  parameter int NTHR = 2
) (
  input wire logic i_clk_sys, // clock
  input wire logic i_nrst, // sync reset, active low
  input wire logic i_llc_flush_done, // shared cache flushed
  input wire logic [3:0] o_pkg_state, // package code
  input wire logic [NCORE-1:0] o_core_pwr_en, // core supplies
  input wire logic [NCORE-1:0] o_core_clk_en, // core clocks
  input wire logic [NCORE-1:0] o_core_restore, // restore requests
  input wire logic o_llc_pwr_en, // shared cache supply
  input wire logic o_uncore_pwr_en, // uncore rails
  input wire logic o_io_pwr_en, // io supply
  input wire logic o_clk24_en, // 24 MHz clock
  input wire logic o_ref_clk_en, // reference clock
  input wire logic o_mem_cke, // memory clock enable
  input wire logic o_mem_self_refresh, // self refresh
  input wire logic o_mem_ctx_kept, // context in memory
  input wire logic o_mem_close_banks, // precharge request
  input wire logic o_reboot_req, // reboot on resume
  input wire logic i_bank_open, // a bank open
  input wire logic i_banks_closed_ack // precharge finished
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  halt_code_a: assert property (
    o_pkg_state != pidss_pkg::CS_C1 && o_pkg_state != pidss_pkg::CS_C1E)
    else $error("package shows a halt code");
  clk_before_pwr_a: assert property (
    (~o_core_pwr_en & o_core_clk_en) == '0)
    else $error("clock running on an unpowered core");
  ref_clk_off_a: assert property (
    !o_ref_clk_en |-> o_core_pwr_en == '0)
    else $error("reference clock off with a core powered");
  llc_pwr_off_a: assert property (
    $fell(o_llc_pwr_en) |-> $past(i_llc_flush_done))
    else $error("cache supply dropped before flush done");
  uncore_io_a: assert property (
    !o_uncore_pwr_en && !o_reboot_req |-> o_io_pwr_en && !o_llc_pwr_en)
    else $error("uncore off without io kept or cache off");
  clk24_off_a: assert property (
    !o_clk24_en |-> !o_uncore_pwr_en)
    else $error("24 MHz clock off with uncore powered");
  active_cke_a: assert property (
    o_pkg_state == pidss_pkg::CS_C0 && $stable(o_pkg_state) |-> o_mem_cke)
    else $error("clock enable low while active");
  self_ref_cke_a: assert property (
    o_mem_self_refresh |-> !o_mem_cke)
    else $error("self refresh with clock enable high");
  ctx_kept_a: assert property (
    o_mem_ctx_kept |-> o_mem_self_refresh)
    else $error("context claimed kept without self refresh");
  restore_pwr_a: assert property (
    o_core_restore != '0 |-> o_ref_clk_en &&
      (o_core_pwr_en & o_core_restore) == o_core_restore)
    else $error("restore before supply and clock");
  close_cke_a: assert property (
    o_mem_close_banks |-> o_mem_cke)
    else $error("clock enable low while closing banks");
  pd_entry_a: assert property (
    $fell(o_mem_cke) && !o_mem_self_refresh |->
      $past(i_bank_open) || $past(i_banks_closed_ack))
    else $error("clock enable dropped with banks in doubt");
  soft_off_io_a: assert property (
    !o_io_pwr_en |-> o_reboot_req)
    else $error("io supply off outside soft off");
endmodule : pidss_chk

bind pidss_top pidss_chk #(.NCORE(NCORE), .NTHR(NTHR)) pidss_chk_inst (
  .i_clk_sys, .i_nrst, .i_llc_flush_done, .o_pkg_state, .o_core_pwr_en,
  .o_core_clk_en, .o_core_restore, .o_llc_pwr_en, .o_uncore_pwr_en,
  .o_io_pwr_en, .o_clk24_en, .o_ref_clk_en, .o_mem_cke, .o_mem_self_refresh,
  .o_mem_ctx_kept, .o_mem_close_banks, .o_reboot_req, .i_bank_open,
  .i_banks_closed_ack);

// file: testbench/pidss_far.sv
// model of the cores and memory side answering the sequencer
module pidss_far #(
  parameter int NC = 2
) (
  input wire logic i_clk_sys, // clock
  input wire logic i_nrst, // sync reset, active low
  input wire logic i_slow, // long answer latency
  input wire logic [NC-1:0] o_core_flush, // write-back request
  input wire logic [NC-1:0] o_core_clk_en, // core clocks
  input wire logic [NC-1:0] o_core_save, // save request
  input wire logic [NC-1:0] o_core_restore, // restore request
  input wire logic [NC-1:0] o_core_pwr_en, // core supplies
  input wire logic o_llc_flush, // shared flush request
  input wire logic o_uncore_pwr_en, // uncore rails
  input wire logic o_mem_close_banks, // precharge request
  output logic [NC-1:0] i_flush_done, // write-back finished
  output logic [NC-1:0] i_save_done, // save finished
  output logic [NC-1:0] i_restore_done, // restore finished
  output logic i_llc_flush_done, // shared flush finished
  output logic i_rails_good, // supplies settled
  output logic i_mem_idle, // memory traffic idle
  output logic i_bank_open, // a bank open
  output logic i_banks_closed_ack // precharge finished
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dly;
  logic [3:0] cnt [NC+2];
  logic [NC+1:0] req;
  assign dly = i_slow ? 4'h9 : 4'h1;
  assign req = {o_llc_flush | o_mem_close_banks,
    &o_core_pwr_en & o_uncore_pwr_en,
    o_core_flush | o_core_save | o_core_restore};
  always_ff @(posedge i_clk_sys)
  begin
    for (int c = 0; c < NC + 2; c++)
    begin
      if (!i_nrst || !req[c])
        cnt[c] <= 4'h0;
      else if (cnt[c] != dly)
        cnt[c] <= cnt[c] + 4'h1;
    end
    for (int c = 0; c < NC; c++)
    begin
      i_flush_done[c] <= i_nrst && o_core_flush[c] && cnt[c] == dly;
      i_save_done[c] <= i_nrst && o_core_save[c] && cnt[c] == dly;
      i_restore_done[c] <= i_nrst && o_core_restore[c] && o_core_pwr_en[c] &&
        cnt[c] == dly;
    end
    i_rails_good <= i_nrst && cnt[NC] == dly;
    i_llc_flush_done <= i_nrst && o_llc_flush && cnt[NC+1] == dly;
    i_banks_closed_ack <= i_nrst && o_mem_close_banks && cnt[NC+1] == dly;
    // banks left open on slow runs; memory busy while cores clocked
    i_bank_open <= !i_nrst ||
      i_slow && !(o_mem_close_banks && cnt[NC+1] == dly);
    i_mem_idle <= i_nrst && o_core_clk_en == '0;
  end
endmodule : pidss_far

// file: testbench/test_package_idle_state_sequencer.sv
// self-checking bench for the package idle state sequencer
module test_package_idle_state_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NC = 2;
  localparam int NT = 2;
  integer seed = 38670;
  int fail_count = 0;
  int samples_checked = 0;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_llc_flush_en = 1'b0;
  logic i_wake = 1'b0;
  logic i_slow = 1'b0;
  logic [4*NC*NT-1:0] i_thr_req = '0;
  logic [3:0] i_plat_limit = pidss_pkg::CS_C10;
  logic [1:0] i_sleep_req = pidss_pkg::SLP_S0;
  logic [NC-1:0] i_flush_done, i_save_done, i_restore_done;
  logic i_llc_flush_done, i_rails_good, i_mem_idle, i_bank_open;
  logic i_banks_closed_ack, o_min_op_point, o_llc_flush, o_llc_pwr_en;
  logic [3:0] o_pkg_state;
  logic [NC-1:0] o_core_flush, o_core_clk_en, o_core_save, o_core_restore;
  logic [NC-1:0] o_core_pwr_en;
  logic o_uncore_pwr_en, o_io_pwr_en, o_deepest_regulator_state;
  logic o_ref_clk_en, o_clk24_en, o_mem_close_banks, o_mem_cke;
  logic o_mem_self_refresh, o_mem_ctx_kept, o_reboot_req;
  pidss_top #(.NCORE(NC), .NTHR(NT)) pidss_top_inst (.i_clk_sys, .i_nrst,
    .i_thr_req, .i_plat_limit, .i_llc_flush_en, .i_wake, .i_sleep_req,
    .i_flush_done, .i_save_done, .i_restore_done, .i_llc_flush_done,
    .i_rails_good, .i_mem_idle, .i_bank_open, .i_banks_closed_ack,
    .o_pkg_state, .o_min_op_point, .o_core_flush, .o_core_clk_en,
    .o_core_save, .o_core_restore, .o_core_pwr_en, .o_llc_flush,
    .o_llc_pwr_en, .o_uncore_pwr_en, .o_io_pwr_en, .o_deepest_regulator_state,
    .o_ref_clk_en, .o_clk24_en, .o_mem_close_banks, .o_mem_cke,
    .o_mem_self_refresh, .o_mem_ctx_kept, .o_reboot_req);
  pidss_far #(.NC(NC)) pidss_far_inst (.i_clk_sys, .i_nrst, .i_slow,
    .o_core_flush, .o_core_clk_en, .o_core_save, .o_core_restore,
    .o_core_pwr_en,
    .o_llc_flush, .o_uncore_pwr_en, .o_mem_close_banks, .i_flush_done,
    .i_save_done, .i_restore_done, .i_llc_flush_done, .i_rails_good,
    .i_mem_idle, .i_bank_open, .i_banks_closed_ack);
  initial
  begin
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("unexpected %s exp %h got %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : tick
  task automatic wait_pkg(logic [3:0] c);
    for (int k = 0; k < 400 && o_pkg_state !== c; k++)
      tick(1);
    tick(2);
  endtask : wait_pkg
  task automatic set_all(logic [3:0] c);
    i_thr_req = {NC*NT{c}};
  endtask : set_all
  // expected supplies and clocks for a package depth
  function automatic logic [15:0] exp_pw(int d);
    exp_pw = {9'h0, d < pidss_pkg::CS_C6, d < pidss_pkg::CS_C7,
      d < pidss_pkg::CS_C9, d < pidss_pkg::CS_C10, d == pidss_pkg::CS_C10,
      1'b1, d < pidss_pkg::CS_C6};
  endfunction : exp_pw
  function automatic logic [15:0] got_pw();
    got_pw = {9'h0, o_ref_clk_en, o_llc_pwr_en, o_uncore_pwr_en, o_clk24_en,
      o_deepest_regulator_state, o_io_pwr_en, |o_core_pwr_en};
  endfunction : got_pw
  task automatic wake_up();
    set_all(pidss_pkg::CS_C0);
    i_sleep_req = pidss_pkg::SLP_S0;
    i_wake = 1'b1;
    wait_pkg(pidss_pkg::CS_C0);
    i_wake = 1'b0;
    chk("wake power", exp_pw(0), got_pw());
    chk("wake clk", 16'h3, {14'h0, o_core_clk_en});
  endtask : wake_up
  initial
  begin
    tick(4);
    i_nrst = 1'b1;
    tick(2);
    chk("reset power", exp_pw(0), got_pw());
    chk("reset cke", 16'h1, 16'(o_mem_cke));
    $display("test reset done");
    for (int h = 1; h < 3; h++)
    begin
      set_all(4'(h));
      tick(20);
      chk("halt pkg", 16'h0, 16'(o_pkg_state));
      chk("min point", 16'(h == 2), 16'(o_min_op_point));
      set_all(pidss_pkg::CS_C0);
      tick(2);
    end
    $display("test halt done");
    set_all(pidss_pkg::CS_C10);
    i_thr_req[4*($random(seed) & 3)+:4] = pidss_pkg::CS_C1;
    tick(30);
    chk("mixed pkg", 16'h0, 16'(o_pkg_state));
    set_all(pidss_pkg::CS_C0);
    tick(2);
    $display("test mixed done");
    for (int d = 4; d < 10; d++)
    begin
      for (int n = 0; n < NC * NT; n++)
        i_thr_req[4*n+:4] = 4'(d + ({$random(seed)} % (10 - d)));
      i_thr_req[3:0] = 4'(d);
      if ($random(seed) & 1)
      begin
        set_all(pidss_pkg::CS_C10);
        i_plat_limit = 4'(d);
      end
      i_slow = 1'($random(seed));
      i_llc_flush_en = 1'($random(seed));
      wait_pkg(4'(d));
      chk("depth pkg", 16'(d), 16'(o_pkg_state));
      chk("depth power", exp_pw(d), got_pw());
      chk("core clk", 16'h0, {14'h0, o_core_clk_en});
      wake_up();
      i_plat_limit = pidss_pkg::CS_C10;
    end
    $display("test depth done");
    for (int s = 1; s < 4; s += 2)
    begin
      i_sleep_req = 2'(s);
      set_all(pidss_pkg::CS_C10);
      wait_pkg(pidss_pkg::CS_C10);
      chk("mem sleep", {13'h0, 1'b1, 1'b0, s == 1},
        {13'h0, o_mem_self_refresh, o_mem_cke, o_mem_ctx_kept});
      chk("reboot", 16'(s == 3), 16'(o_reboot_req));
      wake_up();
    end
    $display("test sleep done");
    close_out();
  end
  initial
  begin
    repeat (30000) @(posedge i_clk_sys);
    fail_count++;
    close_out();
  end
endmodule : test_package_idle_state_sequencer
